/* File: verilog/sxp_pkg.sv */
package sxp_pkg;
    // bus widths
    localparam int AD_W  = 64;
    localparam int CMD_W = 9;

    // command bus layout: bit 8 tells an address cycle from a data cycle
    localparam int CMD_KIND_BIT = 8;
    localparam int CMD_TYPE_HI  = 7;
    localparam int CMD_TYPE_LO  = 5;
    localparam int RD_ATTR_HI   = 4;
    localparam int RD_ATTR_LO   = 3;

    // request types carried in bits 7:5 of an address cycle
    localparam logic [2:0] REQ_READ  = 3'h0;
    localparam logic [2:0] REQ_WRITE = 3'h2;
    localparam logic [2:0] REQ_NULL  = 3'h3;

    // read attribute value for a non-coherent block read
    localparam logic [1:0] RD_BLOCK = 2'h2;

    // data identifier flags
    localparam int DID_LAST = 7;
    localparam int DID_RESP = 6;
    localparam int DID_ERR  = 5;

    // synchroniser depth for pins
    localparam int SYNC_STAGES = 2;

    // reset values of the pin drivers
    localparam logic       RELEASE_N_RST = 1'h1;
    localparam logic       OUT_VALID_RST = 1'h1;
    localparam logic       BUS_OE_RST    = 1'h1;
    localparam logic [8:0] CMD_RST       = 9'h000;
    localparam logic [8:0] IDLE_PINS_RST = 9'h1ff;
endpackage

/* File: verilog/sxp_sync.sv */
`timescale 1ns/1ns
// multi-bit pin synchroniser; only the second stage may read the first
module sxp_sync #(
    parameter int         W      = 1,
    parameter int         STAGES = sxp_pkg::SYNC_STAGES,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] stage [STAGES];

    // fewer than two stages would let metastability reach the logic
    if (STAGES < 2) begin : g_bad_depth
        $error("sxp_sync needs at least two stages");
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < STAGES; i++) begin
                stage[i] <= RST_VAL;
            end
        end else begin
            stage[0] <= d;
            for (int i = 1; i < STAGES; i++) begin
                stage[i] <= stage[i-1];
            end
        end
    end

    assign q = stage[STAGES-1];
endmodule

/* File: verilog/sxp_port.sv */
`timescale 1ns/1ns
// Summary of operation
// RULE1 - external requests only in slave state
// RULE2 - release pulse one cycle when request accepted
// RULE3 - agent drops single request two cycles later
// RULE4 - agent holds request for back-to-back requests
// RULE5 - no own requests while external request held
// RULE6 - float both buses after release pulse
// RULE7 - agent drives buses two cycles after release
// RULE8 - own requests one cycle after agent floats
// RULE9 - external read and response are indivisible
// RULE10 - agent sends read address, one strobe, floats
// RULE11 - one final response cycle, then keep driving
// RULE12 - external read answered with error identifier
// RULE13 - null request returns interface to master
// RULE14 - external write: address then final data cycle
// RULE15 - external accesses address exactly one word
// RULE16 - read response only after own slave entry
// RULE17 - block read response sets line exclusive dirty
// RULE18 - errored response cycles raise bus error
// RULE19 - response only for an outstanding read
// RULE20 - up to one double word per cycle
// RULE21 - data valid needs strobe and data identifier
// RULE22 - command bit 8 marks data identifier
// RULE23 - bits 7:5 read, write or null
// RULE24 - agent holds request until release seen
module sxp_port #(
    parameter int AD_W = sxp_pkg::AD_W
) (
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      ext_request_n,
    input  wire logic                      inbound_valid_n,
    output logic                           release_n,
    output logic                           outbound_valid_n,
    input  wire logic [AD_W-1:0]           addr_data_bus_in,
    output logic      [AD_W-1:0]           addr_data_bus_out,
    output logic                           addr_data_bus_oe,
    input  wire logic [sxp_pkg::CMD_W-1:0] cmd_bus_in,
    output logic      [sxp_pkg::CMD_W-1:0] cmd_bus_out,
    output logic                           cmd_bus_oe,
    input  wire logic                      core_req,
    input  wire logic [sxp_pkg::CMD_W-1:0] core_cmd,
    input  wire logic [AD_W-1:0]           core_addr,
    input  wire logic [AD_W-1:0]           core_wdata,
    input  wire logic [sxp_pkg::CMD_W-1:0] core_wid,
    output logic                           core_ack,
    output logic                           rsp_valid,
    output logic      [AD_W-1:0]           rsp_data,
    output logic                           rsp_last,
    output logic                           rsp_error,
    output logic                           bus_error,
    output logic                           line_excl_dirty,
    output logic                           ext_wr_valid,
    output logic      [AD_W-1:0]           ext_wr_addr,
    output logic      [AD_W-1:0]           ext_wr_data
);
    localparam int SW = 2 + sxp_pkg::CMD_W + AD_W;

    if (AD_W != 64) begin : g_bad_width
        $error("sxp_port carries one double word per cycle, AD_W must be 64");
    end

    typedef enum logic [2:0] {
        ST_MASTER, ST_ADDR, ST_WDATA, ST_RELEASE, ST_SLAVE, ST_EXT_WDATA, ST_RESP, ST_TURN
    } sxp_state_e;

    sxp_state_e                  state;
    sxp_state_e                  next_state;
    logic [SW-1:0]               sync_q;
    logic                        ext_req_s;
    logic                        in_valid_s;
    logic [sxp_pkg::CMD_W-1:0]   in_cmd;
    logic [AD_W-1:0]             in_ad;
    logic                        in_addr_cyc;
    logic                        in_data_cyc;
    logic                        read_pending;
    logic                        pending_block;
    logic                        err_seen;

    function automatic logic [2:0] req_type(input logic [sxp_pkg::CMD_W-1:0] c);
        req_type = c[sxp_pkg::CMD_TYPE_HI:sxp_pkg::CMD_TYPE_LO];
    endfunction

    // every pin input passes two flops before any decoding
    sxp_sync #(
        .W       (SW),
        .STAGES  (sxp_pkg::SYNC_STAGES),
        .RST_VAL ({2'h3, {(SW-2){1'b0}}})
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({ext_request_n, inbound_valid_n, cmd_bus_in, addr_data_bus_in}),
        .q     (sync_q)
    );

    assign ext_req_s  = !sync_q[SW-1];
    assign in_valid_s = !sync_q[SW-2];
    assign in_cmd     = sync_q[AD_W +: sxp_pkg::CMD_W];
    assign in_ad      = sync_q[AD_W-1:0];
    // a strobe alone is not enough, bit 8 decides the cycle kind
    assign in_addr_cyc = in_valid_s && !in_cmd[sxp_pkg::CMD_KIND_BIT]; // RULE22
    assign in_data_cyc = in_valid_s && in_cmd[sxp_pkg::CMD_KIND_BIT]; // RULE21

    // arbitration and sequencing; external requests win over own ones
    always_comb begin
        next_state = state;
        unique case (state)
            ST_MASTER: begin
                if (read_pending || ext_req_s) begin
                    next_state = ST_RELEASE; // RULE5
                end else if (core_req) begin
                    next_state = ST_ADDR;
                end
            end
            ST_ADDR: begin
                next_state = (req_type(core_cmd) == sxp_pkg::REQ_READ) ? ST_RELEASE : ST_WDATA;
            end
            ST_WDATA:   next_state = ext_req_s ? ST_RELEASE : ST_MASTER;
            ST_RELEASE: next_state = ST_SLAVE; // RULE2
            ST_SLAVE: begin
                // external requests are decoded only here, in slave state
                if (in_addr_cyc) begin // RULE1
                    unique case (req_type(in_cmd)) // RULE23
                        sxp_pkg::REQ_READ:  next_state = ST_RESP; // RULE9
                        sxp_pkg::REQ_WRITE: next_state = ST_EXT_WDATA;
                        sxp_pkg::REQ_NULL:  next_state = ST_TURN; // RULE13
                        default:            next_state = ST_SLAVE;
                    endcase
                end else if (in_data_cyc && read_pending && in_cmd[sxp_pkg::DID_LAST]) begin
                    next_state = ST_TURN;
                end
            end
            ST_EXT_WDATA: begin
                if (in_data_cyc && in_cmd[sxp_pkg::DID_LAST]) begin // RULE14
                    next_state = ST_TURN;
                end
            end
            ST_RESP: next_state = ext_req_s ? ST_RELEASE : ST_MASTER; // RULE11
            // one idle cycle so our drivers never overlap the agent's
            ST_TURN: next_state = ext_req_s ? ST_RELEASE : ST_MASTER; // RULE8
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= ST_MASTER;
        end else begin
            state <= next_state;
        end
    end

    // pin drivers, all registered from the next state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            release_n         <= sxp_pkg::RELEASE_N_RST;
            outbound_valid_n  <= sxp_pkg::OUT_VALID_RST;
            addr_data_bus_oe  <= sxp_pkg::BUS_OE_RST;
            cmd_bus_oe        <= sxp_pkg::BUS_OE_RST;
            cmd_bus_out       <= sxp_pkg::CMD_RST;
            addr_data_bus_out <= '0;
        end else begin
            release_n <= (next_state != ST_RELEASE); // RULE2
            // drivers stay on through the release cycle, off after it
            addr_data_bus_oe <= !(next_state inside {ST_SLAVE, ST_EXT_WDATA, ST_TURN}); // RULE6
            cmd_bus_oe <= !(next_state inside {ST_SLAVE, ST_EXT_WDATA, ST_TURN}); // RULE6
            outbound_valid_n <= !(next_state inside {ST_ADDR, ST_WDATA, ST_RESP});
            unique case (next_state)
                ST_ADDR: begin
                    cmd_bus_out       <= core_cmd;
                    addr_data_bus_out <= core_addr;
                end
                ST_WDATA: begin
                    cmd_bus_out       <= core_wid;
                    addr_data_bus_out <= core_wdata;
                end
                ST_RESP: begin
                    // nothing here is externally readable: error data only
                    cmd_bus_out <= sxp_pkg::CMD_RST;
                    cmd_bus_out[sxp_pkg::CMD_KIND_BIT] <= 1'b1;
                    cmd_bus_out[sxp_pkg::DID_LAST]     <= 1'b1; // RULE11
                    cmd_bus_out[sxp_pkg::DID_RESP]     <= 1'b1; // RULE11
                    cmd_bus_out[sxp_pkg::DID_ERR]      <= 1'b1; // RULE12
                    addr_data_bus_out <= '0;
                end
                default: begin
                    cmd_bus_out       <= sxp_pkg::CMD_RST;
                    addr_data_bus_out <= '0;
                end
            endcase
        end
    end

    // own read bookkeeping; cleared by the final response cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            read_pending  <= 1'b0;
            pending_block <= 1'b0;
            err_seen      <= 1'b0;
            core_ack      <= 1'b0;
        end else begin
            // ack the cycle after the address cycle so a held core_req is never issued twice
            core_ack <= state == ST_ADDR;
            if (state == ST_ADDR && req_type(core_cmd) == sxp_pkg::REQ_READ) begin
                read_pending  <= 1'b1;
                pending_block <= core_cmd[sxp_pkg::RD_ATTR_HI:sxp_pkg::RD_ATTR_LO]
                                 == sxp_pkg::RD_BLOCK;
                err_seen      <= 1'b0;
            end else if (state == ST_SLAVE && in_data_cyc && read_pending) begin // RULE16
                err_seen <= err_seen || in_cmd[sxp_pkg::DID_ERR];
                if (in_cmd[sxp_pkg::DID_LAST]) begin
                    read_pending <= 1'b0;
                end
            end
        end
    end

    // read response data towards the core
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rsp_valid       <= 1'b0;
            rsp_data        <= '0;
            rsp_last        <= 1'b0;
            rsp_error       <= 1'b0;
            bus_error       <= 1'b0;
            line_excl_dirty <= 1'b0;
        end else begin
            // paced strobes simply leave gaps, every strobed cycle is taken
            rsp_valid <= state == ST_SLAVE && in_data_cyc && read_pending; // RULE20
            rsp_last  <= in_cmd[sxp_pkg::DID_LAST];
            rsp_error <= in_cmd[sxp_pkg::DID_ERR];
            rsp_data  <= in_ad;
            bus_error <= state == ST_SLAVE && in_data_cyc && read_pending
                         && in_cmd[sxp_pkg::DID_LAST]
                         && (err_seen || in_cmd[sxp_pkg::DID_ERR]); // RULE18
            // prior line state is not looked at, the fill always wins
            line_excl_dirty <= state == ST_SLAVE && in_data_cyc && read_pending
                               && in_cmd[sxp_pkg::DID_LAST] && pending_block; // RULE17
        end
    end

    // external single-word writes towards the core
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_wr_valid <= 1'b0;
            ext_wr_addr  <= '0;
            ext_wr_data  <= '0;
        end else begin
            ext_wr_valid <= state == ST_EXT_WDATA && in_data_cyc && in_cmd[sxp_pkg::DID_LAST];
            if (state == ST_SLAVE && in_addr_cyc && req_type(in_cmd) == sxp_pkg::REQ_WRITE) begin
                ext_wr_addr <= in_ad;
            end
            if (state == ST_EXT_WDATA && in_data_cyc) begin
                ext_wr_data <= in_ad;
            end
        end
    end

    sequence s_ext_read_cmd;
        state == ST_SLAVE && in_addr_cyc && req_type(in_cmd) == sxp_pkg::REQ_READ;
    endsequence

    sequence s_err_response;
        !outbound_valid_n && cmd_bus_oe && cmd_bus_out[sxp_pkg::DID_LAST]
        && cmd_bus_out[sxp_pkg::DID_RESP] && cmd_bus_out[sxp_pkg::DID_ERR];
    endsequence

    property p_release_one;
        @(posedge clk) disable iff (reset) $fell(release_n) |=> release_n;
    endproperty
    a_release_one: assert property (p_release_one) else $error("release pulse too long"); // RULE2

    property p_float_after_release;
        @(posedge clk) disable iff (reset)
            !release_n |=> !addr_data_bus_oe && !cmd_bus_oe;
    endproperty
    a_float_after_release: assert property (p_float_after_release) // RULE6
        else $error("bus still driven after release");

    property p_read_answer;
        @(posedge clk) disable iff (reset)
            s_ext_read_cmd |=> s_err_response ##1 (outbound_valid_n && cmd_bus_oe);
    endproperty
    a_read_answer: assert property (p_read_answer) // RULE11
        else $error("external read not answered in one cycle");

    property p_err_flag;
        @(posedge clk) disable iff (reset)
            s_ext_read_cmd |=> cmd_bus_out[sxp_pkg::DID_ERR] && cmd_bus_out[sxp_pkg::CMD_KIND_BIT];
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("read answer lacks error bit"); // RULE12

    property p_no_split;
        @(posedge clk) disable iff (reset)
            s_ext_read_cmd |=> release_n && outbound_valid_n == 1'b0;
    endproperty
    a_no_split: assert property (p_no_split) else $error("external read interrupted"); // RULE9

    property p_yield;
        @(posedge clk) disable iff (reset)
            state == ST_MASTER && ext_req_s |=> !release_n;
    endproperty
    a_yield: assert property (p_yield) else $error("own request taken over external"); // RULE5

    property p_turn_quiet;
        @(posedge clk) disable iff (reset)
            $rose(cmd_bus_oe) && state != ST_RESP |-> $past(state) == ST_TURN;
    endproperty
    a_turn_quiet: assert property (p_turn_quiet) // RULE8
        else $error("drivers on without idle cycle");

    property p_invalid_ignored;
        @(posedge clk) disable iff (reset)
            !in_valid_s |=> !rsp_valid && !ext_wr_valid;
    endproperty
    a_invalid_ignored: assert property (p_invalid_ignored) // RULE21
        else $error("data taken without strobe");

    property p_bus_error;
        @(posedge clk) disable iff (reset)
            rsp_valid && rsp_last && rsp_error |-> bus_error;
    endproperty
    a_bus_error: assert property (p_bus_error) else $error("errored response lost"); // RULE18
endmodule

/* File: sim/sxp_agent.sv */
`timescale 1ns/1ns
// external agent model; driven pins move 2 ns after a rising edge, the floated bus value flips on the edge
module sxp_agent (
    input  wire logic                      clk,
    input  wire logic                      release_n,
    output logic                           ext_request_n,
    output logic                           inbound_valid_n,
    output logic      [sxp_pkg::AD_W-1:0]  ag_ad,
    output logic      [sxp_pkg::CMD_W-1:0] ag_cmd
);
    logic                      drv;
    logic [sxp_pkg::AD_W-1:0]  drv_ad;
    logic [sxp_pkg::CMD_W-1:0] drv_cmd;
    logic [sxp_pkg::AD_W-1:0]  flt;

    // a floated bus flips every cycle so stale values never pass as data
    initial begin
        ext_request_n = 1'b1;
        inbound_valid_n = 1'b1;
        drv = 1'b0;
        flt = 64'h5a5a_0f0f_3c3c_9696;
        forever @(posedge clk) flt <= ~flt;
    end

    assign ag_ad  = drv ? drv_ad : flt;
    assign ag_cmd = drv ? drv_cmd : flt[8:0];

    // bounded wait for the release pulse
    task automatic wait_release(output bit ok);
        ok = 1'b0;
        for (int n = 0; n < 300 && !ok; n++) begin
            @(posedge clk);
            ok = (release_n === 1'b0);
        end
    endtask

    // drive one bus cycle; the strobe is left for the caller to end
    task automatic put(input logic [8:0] c, input logic [63:0] d, input bit strobe);
        drv = 1'b1;
        drv_cmd = c;
        drv_ad = d;
        inbound_valid_n = !strobe;
        @(posedge clk);
        #2;
    endtask

    // request issued while already slave: address cycle, optional final data
    task automatic slave_op(input logic [8:0] c, input logic [63:0] a, input bit wr,
                            input logic [63:0] d);
        put(c, a, 1'b1);
        if (wr) put(9'h180, d, 1'b1);
        drv = 1'b0;
        inbound_valid_n = 1'b1;
    endtask

    // arbitrate first; more keeps the request line low for a following request
    task automatic ext_op(input logic [8:0] c, input logic [63:0] a, input bit wr,
                          input logic [63:0] d, input bit more, output bit ok);
        ext_request_n = 1'b0;
        wait_release(ok);
        @(posedge clk);
        #2;
        ext_request_n = more ? 1'b0 : 1'b1;
        if (ok) slave_op(c, a, wr, d);
    endtask

    // read answer: unstrobed decoys in the gaps, errors as the mask says
    task automatic respond(input int n, input logic [7:0] err, input logic [63:0] base,
                           input int gap, output bit ok);
        wait_release(ok);
        @(posedge clk);
        #2;
        for (int i = 0; ok && i < n; i++) begin
            repeat (gap) put(9'h1c0, ~base, 1'b0);
            put({1'b1, i == n - 1, 1'b1, err[i], 5'h00}, base + i, 1'b1);
        end
        drv = 1'b0;
        inbound_valid_n = 1'b1;
    endtask
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ns
// bench top: design, agent model, random reads and pin checks
module tb;
    logic                       clk, reset, ext_request_n, inbound_valid_n, release_n;
    logic                       outbound_valid_n, ad_oe, cmd_oe, core_req, core_ack;
    logic                       rsp_valid, rsp_last, rsp_error, bus_error;
    logic                       line_excl_dirty, ext_wr_valid, busy, exp_blk;
    logic                       rel_q = 1'b1;
    logic [sxp_pkg::AD_W-1:0]   ad_out, ad_in, ag_ad, core_addr, core_wdata, rsp_data;
    logic [sxp_pkg::AD_W-1:0]   ext_wr_addr, ext_wr_data, exp_base;
    logic [sxp_pkg::CMD_W-1:0]  cmd_out, cmd_in, ag_cmd, core_cmd, core_wid;
    logic [7:0]                 exp_err;
    logic [31:0]                rng = 32'h8707;
    int                         fail_count, compares, rsp_idx, exp_n, rd_resp, wr_seen;

    sxp_port dut (.clk(clk), .reset(reset), .ext_request_n(ext_request_n),
        .inbound_valid_n(inbound_valid_n), .release_n(release_n),
        .outbound_valid_n(outbound_valid_n), .addr_data_bus_in(ad_in),
        .addr_data_bus_out(ad_out), .addr_data_bus_oe(ad_oe), .cmd_bus_in(cmd_in),
        .cmd_bus_out(cmd_out), .cmd_bus_oe(cmd_oe), .core_req(core_req),
        .core_cmd(core_cmd), .core_addr(core_addr), .core_wdata(core_wdata),
        .core_wid(core_wid), .core_ack(core_ack), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_error(rsp_error),
        .bus_error(bus_error), .line_excl_dirty(line_excl_dirty),
        .ext_wr_valid(ext_wr_valid), .ext_wr_addr(ext_wr_addr),
        .ext_wr_data(ext_wr_data));
    sxp_agent agent (.clk(clk), .release_n(release_n), .ext_request_n(ext_request_n),
        .inbound_valid_n(inbound_valid_n), .ag_ad(ag_ad), .ag_cmd(ag_cmd));

    // whoever has the enable owns the wire
    assign ad_in  = ad_oe ? ad_out : ag_ad;
    assign cmd_in = cmd_oe ? cmd_out : ag_cmd;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // pin watch: release width, turnaround, read answers, response data
    always @(posedge clk) begin
        if (rel_q === 1'b0) begin
            chk(release_n, 1'b1);
            chk({ad_oe, cmd_oe}, 2'b00);
        end
        rel_q <= release_n;
        if (busy === 1'b1) chk(core_ack, 1'b0);
        if (ext_wr_valid === 1'b1) wr_seen++;
        // own cycles go out while the core still holds its request
        if (outbound_valid_n === 1'b0 && core_req === 1'b1) begin
            chk(cmd_out, cmd_out[8] ? core_wid : core_cmd);
            chk(ad_out, cmd_out[8] ? core_wdata : core_addr);
        end else if (outbound_valid_n === 1'b0) begin
            chk(cmd_out, 9'h1e0);
            chk(ad_oe, 1'b1);
            rd_resp++;
        end
        if (rsp_valid === 1'b1) begin
            chk(rsp_data, exp_base + rsp_idx);
            chk(rsp_error, exp_err[rsp_idx]);
            chk(rsp_last, rsp_idx == exp_n - 1);
            if (rsp_idx == exp_n - 1) chk({bus_error, line_excl_dirty}, {exp_err != 0, exp_blk});
            rsp_idx++;
        end
    end

    // core read held until taken, for at most 300 cycles; then the request is dropped
    task automatic core_read(input logic [8:0] c, input logic [63:0] a);
        core_cmd = c;
        core_addr = a;
        core_req = 1'b1;
        for (int n = 0; n < 300; n++) begin
            @(posedge clk);
            if (core_ack === 1'b1) break;
        end
        #2;
        core_req = 1'b0;
    endtask

    task automatic wait_master();
        for (int n = 0; n < 40 && !(ad_oe === 1'b1 && cmd_oe === 1'b1); n++) @(posedge clk);
        #2;
        chk({ad_oe, cmd_oe}, 2'b11);
    endtask

    initial begin
        #(20 * 20000);
        fail_count++;
        give_verdict();
    end

    initial begin
        bit          ok;
        logic [63:0] a;
        logic [63:0] d;
        logic [31:0] r;
        int          w;
        reset = 1'b1;
        busy = 1'b0;
        core_req = 1'b0;
        core_cmd = 9'h000;
        core_addr = {rnd(), rnd()};
        core_wdata = {rnd(), rnd()};
        core_wid = 9'h180;
        repeat (8) @(posedge clk);
        #2;
        reset = 1'b0;
        chk({release_n, outbound_valid_n, ad_oe, cmd_oe}, 4'hf);
        agent.ext_op(9'h060, 64'h0, 1'b0, 64'h0, 1'b0, ok);
        wait_master();
        // own single write: address cycle then final data cycle, no release
        core_read(9'h043, {rnd(), rnd()});
        // single writes then reads of one word
        for (int k = 0; k < 4; k++) begin
            a = {rnd(), rnd()};
            d = {rnd(), rnd()};
            w = wr_seen;
            agent.ext_op(9'h043, a, 1'b1, d, 1'b0, ok);
            wait_master();
            chk(wr_seen, w + 1);
            chk(ext_wr_addr, a);
            chk(ext_wr_data, d);
            w = rd_resp;
            agent.ext_op(9'h01b, a, 1'b0, 64'h0, 1'b0, ok);
            wait_master();
            chk(rd_resp, w + 1);
        end
        // reserved type is ignored; still slave, so null goes out at once
        agent.ext_op(9'h020, a, 1'b0, 64'h0, 1'b0, ok);
        repeat (6) @(posedge clk);
        #2;
        chk({ad_oe, cmd_oe}, 2'b00);
        agent.slave_op(9'h060, 64'h0, 1'b0, 64'h0);
        wait_master();
        // back-to-back requests hold off a waiting core read
        {exp_base, exp_n, exp_err, exp_blk, rsp_idx} = {d, 32'd1, 8'h00, 1'b0, 32'd0};
        busy = 1'b1;
        fork
            begin
                agent.ext_op(9'h043, a, 1'b1, d, 1'b1, ok);
                agent.ext_op(9'h060, a, 1'b0, 64'h0, 1'b0, ok);
                busy = 1'b0;
            end
            begin
                repeat (8) @(posedge clk);
                #2;
                core_read(9'h01b, a);
            end
            begin
                wait (busy == 1'b0);
                agent.respond(1, 8'h00, d, 0, ok);
            end
        join
        wait_master();
        chk(rsp_idx, 1);
        // random word and block reads, paced and with error cycles
        for (int k = 0; k < 12; k++) begin
            r = rnd();
            exp_n = (r[0] || k == 0) ? 8 : 1;
            exp_blk = (exp_n == 8);
            exp_base = {rnd(), rnd()};
            exp_err = (r[1] || k == 0) ? r[15:8] & (exp_blk ? 8'hff : 8'h01) : 8'h00;
            rsp_idx = 0;
            fork
                core_read(exp_blk ? 9'h011 : 9'h01b, {rnd(), rnd()});
                agent.respond(exp_n, exp_err, exp_base, r[17:16] % 3, ok);
            join
            wait_master();
            chk(rsp_idx, exp_n);
        end
        give_verdict();
    end
endmodule
